// ==== src/cmmd_memory_map.sv ====
`timescale 1ns/10ps
`include "cmmd_regs.svh"
// Functional notes
// - Program counter resets to FF0000H.
// - Extended data pointer upper byte resets to 01H.
// - Stack pointer resets to 00:0007H.
// - Upper address byte is the 64 KB region number.
// - Only regions 00, 01, FE and FF exist.
// - Program memory and optional 16 KB on-chip store live in FF.
// - External data memory lives in region 01.
// - Program memory is never mapped into region 00.
// - Nothing is ever fetched from on-chip data RAM.
// - External cycles drive only the low 16 address bits.
// - Read, write and fetch strobes are separate per access kind.
// - SFR space is 80H to FFH, separate from memory.
// - Every SFR is bit addressable.
// - 00:0000H-001FH are four banks of eight byte registers.
// - One KB on-chip RAM at 00:0020H-041FH.
// - 00:0020H-007FH is bit addressable.
// - 00:0420H-FFFFH goes to external memory for stack.
// - Data and stack pointers share storage in register file and SFRs.
// - 40-byte register file, written one byte at a time; size is ignored.
// - One state is two clocks; external fetch takes two states.
module cmmd_memory_map #(
    parameter bit HAS_ROM = 1'b1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             req,
    input  wire cmmd_pkg::cmmd_kind_t kind,
    input  wire logic [23:0]      addr,
    input  wire logic [1:0]       size,
    input  wire logic             bit_op,
    input  wire logic [2:0]       bit_sel,
    input  wire logic [31:0]      wdata,
    input  wire logic             rf_sel,
    input  wire logic [5:0]       rf_addr,
    input  wire logic [1:0]       bank_sel,
    input  wire logic             pc_load,
    input  wire logic [23:0]      pc_value,
    input  wire logic [7:0]       ext_data_in,
    input  wire logic [7:0]       rom_data,
    output logic                  busy,
    output logic                  done,
    output logic [31:0]           rdata,
    output logic                  fault,
    output logic [23:0]           pc,
    output logic [23:0]           data_pointer_ext,
    output logic [15:0]           stack_pointer,
    output logic [15:0]           ext_addr,
    output logic [7:0]            ext_data_out,
    output logic                  ext_data_oe_n,
    output logic                  read_strobe_n,
    output logic                  write_strobe_n,
    output logic                  program_fetch_strobe_n,
    output logic [13:0]           rom_addr
);
    localparam int RFB = `CMMD_REGFILE_BYTES;
    localparam int RAMB = `CMMD_RAM_BYTES;

    logic [7:0]  reg_file [0:RFB-1];
    logic [7:0]  ram [0:RAMB-1];
    logic [7:0]  sfr [0:127];
    logic [7:0]  bank_byte_registers [0:31];
    cmmd_pkg::cmmd_state_t state;
    cmmd_pkg::cmmd_state_t next_state;
    cmmd_pkg::cmmd_target_t target;
    cmmd_pkg::cmmd_target_t cur_target;
    cmmd_pkg::cmmd_kind_t   cur_kind;
    logic [23:0] cur_addr;
    logic [7:0]  cur_wdata;
    logic        cur_bit;
    logic [2:0]  cur_bitsel;
    logic [7:0]  rd_byte;
    logic [7:0]  next_byte;
    logic        is_ext;
    logic [5:0]  rf_index;
    logic [15:0] data_pointer_16;
    logic        ext_last;

    cmmd_region_decode #(.HAS_ROM(HAS_ROM)) u_dec (
        .addr   (addr),
        .kind   (kind),
        .target (target)
    );

    assign data_pointer_16 = data_pointer_ext[15:0];
    assign is_ext = (cur_target == cmmd_pkg::CMMD_T_EXTSTK) ||
                    (cur_target == cmmd_pkg::CMMD_T_XDATA) ||
                    (cur_target == cmmd_pkg::CMMD_T_ALT) ||
                    (cur_target == cmmd_pkg::CMMD_T_EXTPRG);

    // Register file indices 0..7 alias the active bank's byte registers.
    always_comb begin
        rf_index = rf_addr;
        if (rf_addr >= 6'd56)
            rf_index = 6'(rf_addr - 6'd24);
    end

    always_comb begin
        next_state = state;
        case (state)
            cmmd_pkg::CMMD_S_IDLE: begin
                if (req)
                    next_state = cmmd_pkg::CMMD_S_PH1;
            end
            cmmd_pkg::CMMD_S_PH1: begin
                next_state = cmmd_pkg::CMMD_S_PH2;
            end
            cmmd_pkg::CMMD_S_PH2: begin
                if (is_ext)
                    next_state = cmmd_pkg::CMMD_S_EXT2;
                else
                    next_state = cmmd_pkg::CMMD_S_IDLE;
            end
            cmmd_pkg::CMMD_S_EXT2: begin
                if (ext_last)
                    next_state = cmmd_pkg::CMMD_S_IDLE;
            end
            default: next_state = cmmd_pkg::CMMD_S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst)
            state <= cmmd_pkg::CMMD_S_IDLE;
        else
            state <= next_state;
    end

    // The second external state lasts two clocks; this marks its end.
    always_ff @(posedge clk) begin
        if (rst)
            ext_last <= 1'b0;
        else
            ext_last <= (state == cmmd_pkg::CMMD_S_EXT2) && !ext_last;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur_target <= cmmd_pkg::CMMD_T_NONE;
            cur_kind   <= cmmd_pkg::CMMD_K_READ;
            cur_addr   <= 24'h000000;
            cur_wdata  <= 8'h00;
            cur_bit    <= 1'b0;
            cur_bitsel <= 3'h0;
        end else if (state == cmmd_pkg::CMMD_S_IDLE && req) begin
            cur_target <= target;
            cur_kind   <= kind;
            cur_addr   <= addr;
            cur_wdata  <= wdata[7:0];
            cur_bit    <= bit_op;
            cur_bitsel <= bit_sel;
        end
    end

    // Byte read mux for the latched access.
    always_comb begin
        rd_byte = `CMMD_UNMAPPED_READ;
        case (cur_target)
            cmmd_pkg::CMMD_T_BANK:
                rd_byte = bank_byte_registers[cur_addr[4:0]];
            cmmd_pkg::CMMD_T_BITRAM, cmmd_pkg::CMMD_T_RAM:
                rd_byte = ram[10'(cur_addr[15:0] - 16'h0020)];
            cmmd_pkg::CMMD_T_SFR: begin
                if (cur_addr[7:0] == `CMMD_SFR_DPL)
                    rd_byte = data_pointer_ext[7:0];
                else if (cur_addr[7:0] == `CMMD_SFR_DPH)
                    rd_byte = data_pointer_ext[15:8];
                else if (cur_addr[7:0] == `CMMD_SFR_DPX)
                    rd_byte = data_pointer_ext[23:16];
                else if (cur_addr[7:0] == `CMMD_SFR_SPL)
                    rd_byte = stack_pointer[7:0];
                else if (cur_addr[7:0] == `CMMD_SFR_SPH)
                    rd_byte = stack_pointer[15:8];
                else
                    rd_byte = sfr[cur_addr[6:0]];
            end
            cmmd_pkg::CMMD_T_ROM:
                rd_byte = rom_data;
            cmmd_pkg::CMMD_T_EXTSTK, cmmd_pkg::CMMD_T_XDATA,
            cmmd_pkg::CMMD_T_ALT, cmmd_pkg::CMMD_T_EXTPRG:
                rd_byte = ext_data_in;
            default: rd_byte = `CMMD_UNMAPPED_READ;
        endcase
    end

    // Bit writes may hit any SFR or the bit RAM, not only X0H/X8H.
    always_comb begin
        next_byte = cur_wdata;
        if (cur_bit && (cur_target == cmmd_pkg::CMMD_T_SFR ||
                        cur_target == cmmd_pkg::CMMD_T_BITRAM)) begin
            next_byte = rd_byte;
            next_byte[cur_bitsel] = cur_wdata[0];
        end
    end

    logic do_write;
    // An SFR access always writes and returns the old byte, so software
    // reads an SFR by exchanging it.
    assign do_write = (state == cmmd_pkg::CMMD_S_PH2) &&
                      (cur_kind == cmmd_pkg::CMMD_K_WRITE ||
                       cur_kind == cmmd_pkg::CMMD_K_SFR);

    always_ff @(posedge clk) begin
        if (do_write && (cur_target == cmmd_pkg::CMMD_T_BITRAM ||
                         cur_target == cmmd_pkg::CMMD_T_RAM))
            ram[10'(cur_addr[15:0] - 16'h0020)] <= next_byte;
    end

    always_ff @(posedge clk) begin
        if (do_write && cur_target == cmmd_pkg::CMMD_T_SFR &&
            cur_addr[7:0] != `CMMD_SFR_DPL &&
            cur_addr[7:0] != `CMMD_SFR_DPH &&
            cur_addr[7:0] != `CMMD_SFR_DPX &&
            cur_addr[7:0] != `CMMD_SFR_SPL &&
            cur_addr[7:0] != `CMMD_SFR_SPH)
            sfr[cur_addr[6:0]] <= next_byte;
    end

    // Banks are shared by memory writes and register-file writes at 0..7.
    always_ff @(posedge clk) begin
        if (do_write && cur_target == cmmd_pkg::CMMD_T_BANK)
            bank_byte_registers[cur_addr[4:0]] <= next_byte;
        else if (rf_sel && rf_addr < 6'd8)
            bank_byte_registers[{bank_sel, rf_addr[2:0]}] <= wdata[7:0];
    end

    // Bytes 8..31 and 56..63 of the file; pointer bytes live elsewhere.
    always_ff @(posedge clk) begin
        if (rf_sel && rf_addr >= 6'd8 && (rf_addr < 6'd32 ||
            (rf_addr >= 6'd56 && rf_addr < `CMMD_RF_DPX) ||
            rf_addr > `CMMD_RF_SPL))
            reg_file[rf_index] <= wdata[7:0];
    end

    // Pointers are one store seen from both the file and SFR space.
    always_ff @(posedge clk) begin
        if (rst) begin
            data_pointer_ext <= {`CMMD_DP_UPPER_RESET, 16'h0000};
            stack_pointer    <= `CMMD_SP_RESET;
        end else if (rf_sel && rf_addr >= `CMMD_RF_DPX &&
                     rf_addr <= `CMMD_RF_SPL) begin
            if (rf_addr == `CMMD_RF_DPX)
                data_pointer_ext[23:16] <= wdata[7:0];
            else if (rf_addr == `CMMD_RF_DPH)
                data_pointer_ext[15:8] <= wdata[7:0];
            else if (rf_addr == `CMMD_RF_DPL)
                data_pointer_ext[7:0] <= wdata[7:0];
            else if (rf_addr == `CMMD_RF_SPH)
                stack_pointer[15:8] <= wdata[7:0];
            else if (rf_addr == `CMMD_RF_SPL)
                stack_pointer[7:0] <= wdata[7:0];
        end else if (do_write && cur_target == cmmd_pkg::CMMD_T_SFR) begin
            if (cur_addr[7:0] == `CMMD_SFR_DPL)
                data_pointer_ext[7:0] <= next_byte;
            else if (cur_addr[7:0] == `CMMD_SFR_DPH)
                data_pointer_ext[15:8] <= next_byte;
            else if (cur_addr[7:0] == `CMMD_SFR_DPX)
                data_pointer_ext[23:16] <= next_byte;
            else if (cur_addr[7:0] == `CMMD_SFR_SPL)
                stack_pointer[7:0] <= next_byte;
            else if (cur_addr[7:0] == `CMMD_SFR_SPH)
                stack_pointer[15:8] <= next_byte;
        end
    end

    always_ff @(posedge clk) begin
        if (rst)
            pc <= `CMMD_PC_RESET;
        else if (pc_load && pc_value[23:16] != `CMMD_REGION_LOCAL)
            pc <= pc_value;
    end

    // External pins; only the low 16 address bits leave the chip.
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_addr               <= 16'h0000;
            ext_data_out           <= 8'h00;
            ext_data_oe_n          <= 1'b1;
            read_strobe_n          <= 1'b1;
            write_strobe_n         <= 1'b1;
            program_fetch_strobe_n <= 1'b1;
            rom_addr               <= 14'h0000;
        end else if (state == cmmd_pkg::CMMD_S_PH1 && is_ext) begin
            ext_addr <= cur_addr[15:0];
            if (cur_kind == cmmd_pkg::CMMD_K_FETCH) begin
                program_fetch_strobe_n <= 1'b0;
            end else if (cur_kind == cmmd_pkg::CMMD_K_WRITE) begin
                write_strobe_n <= 1'b0;
                ext_data_out   <= cur_wdata;
                ext_data_oe_n  <= 1'b0;
            end else begin
                read_strobe_n <= 1'b0;
            end
        end else if (state == cmmd_pkg::CMMD_S_PH1 &&
                     cur_target == cmmd_pkg::CMMD_T_ROM) begin
            rom_addr <= cur_addr[13:0];
        end else if ((state == cmmd_pkg::CMMD_S_EXT2 && ext_last) ||
                     state == cmmd_pkg::CMMD_S_IDLE) begin
            read_strobe_n          <= 1'b1;
            write_strobe_n         <= 1'b1;
            program_fetch_strobe_n <= 1'b1;
            ext_data_oe_n          <= 1'b1;
        end
    end

    // Answer; unmapped or RAM fetches raise fault and return fixed data.
    always_ff @(posedge clk) begin
        if (rst) begin
            done  <= 1'b0;
            rdata <= 32'h00000000;
            fault <= 1'b0;
            busy  <= 1'b0;
        end else begin
            busy <= (next_state != cmmd_pkg::CMMD_S_IDLE);
            done <= (state == cmmd_pkg::CMMD_S_PH2 && !is_ext) ||
                    (state == cmmd_pkg::CMMD_S_EXT2 && ext_last);
            if ((state == cmmd_pkg::CMMD_S_PH2 && !is_ext) ||
                (state == cmmd_pkg::CMMD_S_EXT2 && ext_last)) begin
                rdata <= {24'h000000, rd_byte};
                fault <= (cur_target == cmmd_pkg::CMMD_T_NONE);
            end
        end
    end

    logic [7:0] unused_rf;
    assign unused_rf = reg_file[0] ^ 8'(size) ^ 8'(data_pointer_16[0]);

    a_pc_reset_value: assert property (@(posedge clk)
        $past(rst) && !rst |-> pc == `CMMD_PC_RESET)
        else $error("pc not at reset value");
    a_dp_reset_upper: assert property (@(posedge clk)
        $past(rst) && !rst |->
        data_pointer_ext[23:16] == `CMMD_DP_UPPER_RESET)
        else $error("dp upper byte wrong after reset");
    a_sp_reset_value: assert property (@(posedge clk)
        $past(rst) && !rst |-> stack_pointer == `CMMD_SP_RESET)
        else $error("sp wrong after reset");
    a_pc_not_local: assert property (@(posedge clk) disable iff (rst)
        pc[23:16] != `CMMD_REGION_LOCAL)
        else $error("pc entered region 00");
    a_strobes_exclusive: assert property (@(posedge clk) disable iff (rst)
        $onehot0({~read_strobe_n, ~write_strobe_n,
                  ~program_fetch_strobe_n}))
        else $error("more than one strobe active");
    a_ext_two_states: assert property (@(posedge clk) disable iff (rst)
        (state == cmmd_pkg::CMMD_S_PH1 && is_ext)
        |-> ##4 done)
        else $error("external access not four clocks");
    a_int_one_state: assert property (@(posedge clk) disable iff (rst)
        (state == cmmd_pkg::CMMD_S_PH1 && !is_ext)
        |-> ##2 done)
        else $error("internal access not two clocks");
    a_unmapped_fixed: assert property (@(posedge clk) disable iff (rst)
        (state == cmmd_pkg::CMMD_S_PH2 &&
         cur_target == cmmd_pkg::CMMD_T_NONE)
        |=> rdata == {24'h000000, `CMMD_UNMAPPED_READ} && fault)
        else $error("unmapped read not fixed");
    a_ext_addr_low: assert property (@(posedge clk) disable iff (rst)
        (state == cmmd_pkg::CMMD_S_PH1 && is_ext)
        |=> ext_addr == $past(cur_addr[15:0]))
        else $error("external address wrong");
endmodule

// ==== src/cmmd_regs.svh ====
`ifndef CMMD_REGS_SVH
`define CMMD_REGS_SVH
`define CMMD_PC_RESET        24'hFF0000
`define CMMD_DP_UPPER_RESET  8'h01
`define CMMD_SP_RESET        16'h0007
`define CMMD_REGION_PROG     8'hFF
`define CMMD_REGION_XDATA    8'h01
`define CMMD_REGION_LOCAL    8'h00
`define CMMD_REGION_ALT      8'hFE
`define CMMD_BANK_LAST       16'h001F
`define CMMD_BITRAM_LAST     16'h007F
`define CMMD_RAM_LAST        16'h041F
`define CMMD_ONCHIP_ROM_LAST 16'h3FFF
`define CMMD_SFR_FIRST       8'h80
`define CMMD_UNMAPPED_READ   8'hFF
`define CMMD_REGFILE_BYTES   40
`define CMMD_RAM_BYTES       1024
`define CMMD_SFR_DPL         8'h82
`define CMMD_SFR_DPH         8'h83
`define CMMD_SFR_DPX         8'h84
`define CMMD_SFR_SPL         8'h81
`define CMMD_SFR_SPH         8'hBD
`define CMMD_RF_DPX          6'd57
`define CMMD_RF_DPH          6'd58
`define CMMD_RF_DPL          6'd59
`define CMMD_RF_SPH          6'd60
`define CMMD_RF_SPL          6'd61
`endif

// ==== src/cmmd_pkg.sv ====
package cmmd_pkg;
    typedef enum logic [3:0] {
        CMMD_T_BANK   = 4'h0,
        CMMD_T_BITRAM = 4'h1,
        CMMD_T_RAM    = 4'h2,
        CMMD_T_EXTSTK = 4'h3,
        CMMD_T_XDATA  = 4'h4,
        CMMD_T_ROM    = 4'h5,
        CMMD_T_EXTPRG = 4'h6,
        CMMD_T_ALT    = 4'h7,
        CMMD_T_SFR    = 4'h8,
        CMMD_T_NONE   = 4'h9
    } cmmd_target_t;
    typedef enum logic [1:0] {
        CMMD_K_READ  = 2'b00,
        CMMD_K_WRITE = 2'b01,
        CMMD_K_FETCH = 2'b10,
        CMMD_K_SFR   = 2'b11
    } cmmd_kind_t;
    typedef enum logic [1:0] {
        CMMD_S_IDLE  = 2'b00,
        CMMD_S_PH1   = 2'b01,
        CMMD_S_PH2   = 2'b10,
        CMMD_S_EXT2  = 2'b11
    } cmmd_state_t;
endpackage

// ==== src/cmmd_region_decode.sv ====
`timescale 1ns/10ps
`include "cmmd_regs.svh"
module cmmd_region_decode #(
    parameter bit HAS_ROM = 1'b1
) (
    input  wire logic [23:0]         addr,
    input  wire cmmd_pkg::cmmd_kind_t kind,
    output cmmd_pkg::cmmd_target_t   target
);
    logic [7:0]  region;
    logic [15:0] offs;
    assign region = addr[23:16];
    assign offs   = addr[15:0];
    always_comb begin
        if (kind == cmmd_pkg::CMMD_K_SFR) begin
            if (addr[7:0] >= `CMMD_SFR_FIRST)
                target = cmmd_pkg::CMMD_T_SFR;
            else
                target = cmmd_pkg::CMMD_T_NONE;
        end else if (kind == cmmd_pkg::CMMD_K_FETCH) begin
            // Fetches never come from region 00 or the data RAM.
            if (region == `CMMD_REGION_PROG && HAS_ROM &&
                offs <= `CMMD_ONCHIP_ROM_LAST)
                target = cmmd_pkg::CMMD_T_ROM;
            else if (region == `CMMD_REGION_PROG ||
                     region == `CMMD_REGION_ALT ||
                     region == `CMMD_REGION_XDATA)
                target = cmmd_pkg::CMMD_T_EXTPRG;
            else
                target = cmmd_pkg::CMMD_T_NONE;
        end else if (region == `CMMD_REGION_LOCAL) begin
            if (offs <= `CMMD_BANK_LAST)
                target = cmmd_pkg::CMMD_T_BANK;
            else if (offs <= `CMMD_BITRAM_LAST)
                target = cmmd_pkg::CMMD_T_BITRAM;
            else if (offs <= `CMMD_RAM_LAST)
                target = cmmd_pkg::CMMD_T_RAM;
            else
                target = cmmd_pkg::CMMD_T_EXTSTK;
        end else if (region == `CMMD_REGION_XDATA) begin
            target = cmmd_pkg::CMMD_T_XDATA;
        end else if (region == `CMMD_REGION_ALT) begin
            target = cmmd_pkg::CMMD_T_ALT;
        end else if (region == `CMMD_REGION_PROG) begin
            if (HAS_ROM && offs <= `CMMD_ONCHIP_ROM_LAST)
                target = cmmd_pkg::CMMD_T_ROM;
            else
                target = cmmd_pkg::CMMD_T_EXTPRG;
        end else begin
            target = cmmd_pkg::CMMD_T_NONE;
        end
    end
endmodule

// ==== tb/cmmd_ext_mem.sv ====
`timescale 1ns/10ps
module cmmd_ext_mem (
    input  wire logic        clk,
    input  wire logic [15:0] ext_addr,
    input  wire logic [7:0]  ext_data_out,
    input  wire logic        ext_data_oe_n,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic        program_fetch_strobe_n,
    output logic      [7:0]  ext_data_in
);
    logic [7:0] mem [0:65535];
    logic [7:0] last = 8'h00;
    logic       rd_on;

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end

    assign rd_on = !read_strobe_n || !program_fetch_strobe_n;
    // Released bus shows the inverse so a stale byte can never match.
    assign ext_data_in = rd_on ? mem[ext_addr] : ~last;

    always @(posedge clk) begin
        if (!write_strobe_n && !ext_data_oe_n) begin
            mem[ext_addr] <= ext_data_out;
        end
        if (rd_on) begin
            last <= mem[ext_addr];
        end
    end
endmodule

// ==== tb/cmmd_memory_map_tb.sv ====
`timescale 1ns/10ps
module cmmd_memory_map_tb;
    logic                 clk      = 1'h0;
    logic                 rst      = 1'h1;
    logic                 req      = 1'h0;
    cmmd_pkg::cmmd_kind_t kind     = cmmd_pkg::CMMD_K_READ;
    logic [23:0]          addr     = 24'h000000;
    logic                 bit_op   = 1'h0;
    logic [2:0]           bit_sel  = 3'h0;
    logic [31:0]          wdata    = 32'h00000000;
    logic                 rf_sel   = 1'h0;
    logic [5:0]           rf_addr  = 6'h00;
    logic [1:0]           bank_sel = 2'h0;
    logic                 pc_load  = 1'h0;
    logic [23:0]          pc_value = 24'h000000;
    logic [7:0]           rom_data = 8'h3C;
    logic [7:0]           ext_data_in;
    logic [7:0]           ext_data_out;
    logic                 busy;
    logic                 done;
    logic                 fault;
    logic [31:0]          rdata;
    logic [23:0]          pc;
    logic [23:0]          data_pointer_ext;
    logic [15:0]          stack_pointer;
    logic [15:0]          ext_addr;
    logic                 ext_data_oe_n;
    logic                 read_strobe_n;
    logic                 write_strobe_n;
    logic                 program_fetch_strobe_n;
    logic [13:0]          rom_addr;
    logic [7:0]           got_q;
    logic                 got_f;
    logic [2:0]           got_stb;
    logic [15:0]          got_ea;
    int                   got_lat;
    logic                 got_busy;
    int                   n_fail = 0;
    int                   total_checks = 0;

    localparam cmmd_pkg::cmmd_kind_t RD = cmmd_pkg::CMMD_K_READ;
    localparam cmmd_pkg::cmmd_kind_t WR = cmmd_pkg::CMMD_K_WRITE;
    localparam cmmd_pkg::cmmd_kind_t FE = cmmd_pkg::CMMD_K_FETCH;
    localparam cmmd_pkg::cmmd_kind_t SF = cmmd_pkg::CMMD_K_SFR;

    always #25 clk = ~clk;

    cmmd_memory_map uut (.clk(clk), .rst(rst), .req(req), .kind(kind),
        .addr(addr), .size(2'h0), .bit_op(bit_op), .bit_sel(bit_sel),
        .wdata(wdata), .rf_sel(rf_sel), .rf_addr(rf_addr),
        .bank_sel(bank_sel), .pc_load(pc_load), .pc_value(pc_value),
        .ext_data_in(ext_data_in), .rom_data(rom_data), .busy(busy),
        .done(done), .rdata(rdata), .fault(fault), .pc(pc),
        .data_pointer_ext(data_pointer_ext), .stack_pointer(stack_pointer),
        .ext_addr(ext_addr), .ext_data_out(ext_data_out),
        .ext_data_oe_n(ext_data_oe_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .rom_addr(rom_addr),
        .program_fetch_strobe_n(program_fetch_strobe_n));

    cmmd_ext_mem mem (.clk(clk), .ext_addr(ext_addr),
        .ext_data_out(ext_data_out), .ext_data_oe_n(ext_data_oe_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .program_fetch_strobe_n(program_fetch_strobe_n),
        .ext_data_in(ext_data_in));

    task automatic check(input string n, input logic [23:0] e,
                         input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic complete_run();
        if (n_fail == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Strobes seen are gathered as {fetch, write, read}.
    task automatic acc(input cmmd_pkg::cmmd_kind_t k, input logic [23:0] a,
                       input logic [7:0] d, input logic b);
        @(posedge clk);
        req <= 1'h1;
        kind <= k;
        addr <= a;
        wdata <= {24'h000000, d};
        bit_op <= b;
        @(posedge clk);
        req <= 1'h0;
        got_stb = 3'h0;
        got_lat = 0;
        got_q = 8'h00;
        got_f = 1'h0;
        got_busy = 1'h0;
        for (int i = 1; i <= 8 && got_lat == 0; i++) begin
            @(posedge clk);
            #1;
            if (i == 1) got_busy = busy;
            got_stb |= {program_fetch_strobe_n === 1'h0,
                        write_strobe_n === 1'h0, read_strobe_n === 1'h0};
            if (got_stb != 3'h0) got_ea = ext_addr;
            if (done === 1'h1) begin
                got_lat = i;
                got_q = rdata[7:0];
                got_f = fault;
            end
        end
    endtask

    task automatic rf_write(input logic [5:0] ra, input logic [1:0] bk,
                            input logic [7:0] d);
        @(posedge clk);
        rf_sel <= 1'h1;
        rf_addr <= ra;
        bank_sel <= bk;
        wdata <= {24'h000000, d};
        @(posedge clk);
        rf_sel <= 1'h0;
        @(posedge clk);
        #1;
    endtask

    task automatic t_reset();
        check("pc", 24'hFF0000, pc);
        check("dp", 24'h010000, data_pointer_ext);
        check("sp", 24'h000007, {8'h00, stack_pointer});
        check("strobes", 24'h000007, {21'h0, program_fetch_strobe_n,
              write_strobe_n, read_strobe_n});
        check("idle outs", 24'h000001, {20'h0, busy, done, fault,
              ext_data_oe_n});
    endtask

    task automatic t_xdata();
        acc(WR, 24'h011234, 8'hA5, 1'h0);
        check("wr strobe", 24'h000002, {21'h0, got_stb});
        check("wr addr", 24'h001234, {8'h00, got_ea});
        check("ext lat", 24'h000004, 24'(got_lat));
        check("busy", 24'h000001, {23'h0, got_busy});
        acc(RD, 24'h011234, 8'h00, 1'h0);
        check("rd strobe", 24'h000001, {21'h0, got_stb});
        check("rd data", 24'h0000A5, {16'h0, got_q});
    endtask

    task automatic t_prog();
        acc(FE, 24'hFF8012, 8'h00, 1'h0);
        check("fetch strobe", 24'h000004, {21'h0, got_stb});
        check("fetch addr", 24'h008012, {8'h00, got_ea});
        check("fetch data", 24'h000048, {16'h0, got_q});
        acc(FE, 24'hFF0010, 8'h00, 1'h0);
        check("rom strobe", 24'h000000, {21'h0, got_stb});
        check("rom data", 24'h00003C, {16'h0, got_q});
        check("rom addr", 24'h000010, {10'h0, rom_addr});
        check("int lat", 24'h000002, 24'(got_lat));
    endtask

    task automatic t_local();
        acc(FE, 24'h000100, 8'h00, 1'h0);
        check("ram fetch", 24'h000001, {23'h0, got_f});
        check("ram fetch stb", 24'h000000, {21'h0, got_stb});
        acc(WR, 24'h000030, 8'h96, 1'h0);
        acc(WR, 24'h000030, 8'h01, 1'h1);
        acc(RD, 24'h000030, 8'h00, 1'h0);
        check("ram data", 24'h000097, {16'h0, got_q});
        check("ram stb", 24'h000000, {21'h0, got_stb});
        acc(WR, 24'h00041F, 8'h3E, 1'h0);
        acc(RD, 24'h00041F, 8'h00, 1'h0);
        check("ram top", 24'h00003E, {16'h0, got_q});
        acc(WR, 24'h000500, 8'h77, 1'h0);
        check("stack ext", 24'h050002, {got_ea, 5'h0, got_stb});
    endtask

    task automatic t_unmapped();
        logic [7:0] regs [3] = '{8'h02, 8'h7F, 8'hFD};
        foreach (regs[i]) begin
            acc(WR, {regs[i], 16'h0040}, 8'h11, 1'h0);
            check("unm wr stb", 24'h000000, {21'h0, got_stb});
            acc(RD, {regs[i], 16'h0040}, 8'h00, 1'h0);
            check("unm rd", 24'h0001FF, {15'h0, got_f, got_q});
        end
        acc(RD, 24'hFE0040, 8'h00, 1'h0);
        check("alt rd", 24'h00011A, {13'h0, got_stb, got_q});
        acc(SF, 24'h000040, 8'h00, 1'h0);
        check("unm sfr", 24'h0001FF, {15'h0, got_f, got_q});
    endtask

    task automatic t_bank();
        rf_write(6'h03, 2'h2, 8'h5C);
        acc(RD, 24'h000013, 8'h00, 1'h0);
        check("bank reg", 24'h00005C, {16'h0, got_q});
    endtask

    task automatic t_sfr();
        acc(SF, 24'h000081, 8'h40, 1'h0);
        check("sfr sp", 24'h000040, {8'h00, stack_pointer});
        acc(SF, 24'h000081, 8'h01, 1'h0);
        @(posedge clk);
        bit_sel <= 3'h3;
        acc(SF, 24'h000081, 8'h01, 1'h1);
        check("sfr bit", 24'h000009, {8'h00, stack_pointer});
        rf_write(6'h3D, 2'h0, 8'h55);
        acc(SF, 24'h000081, 8'h00, 1'h0);
        check("sp alias", 24'h000055, {16'h0, got_q});
        acc(SF, 24'h000083, 8'h12, 1'h0);
        check("dp alias", 24'h011200, data_pointer_ext);
    endtask

    // A load into region 00 must not move execution into data RAM.
    task automatic t_pc();
        @(posedge clk);
        pc_load <= 1'h1;
        pc_value <= 24'h001234;
        @(posedge clk);
        pc_value <= 24'hFE0010;
        #1;
        check("pc region 00", 24'hFF0000, pc);
        @(posedge clk);
        pc_load <= 1'h0;
        #1;
        check("pc load", 24'hFE0010, pc);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        #1;
        t_reset();
        t_xdata();
        t_prog();
        t_local();
        t_unmapped();
        t_bank();
        t_sfr();
        t_pc();
        complete_run();
    end

    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        complete_run();
    end
endmodule
